/* File: hw/frp_pkg.sv */
/*
 * Package for the flash read protection gate: protection levels, the
 * programming operation encoding, the carrier of a gating decision and the
 * protection word values.
 * Assumes a single 50 MHz clock domain and a synchronous active-low reset.
 */
package frp_pkg;

    // Protection word values stored in flash; anything else means unprotected
    localparam logic [31:0] FRP_WORD_LEVEL_ONE = 32'h12345678;
    localparam logic [31:0] FRP_WORD_LEVEL_TWO = 32'h87654321;
    localparam logic [31:0] FRP_WORD_LEVEL_THREE = 32'h43218765;

    // Sector that holds the protection word and boot vectors
    localparam logic [7:0] FRP_BOOT_SECTOR = 8'h00;
    // Cycles after reset release before the level is captured
    localparam logic [1:0] FRP_CAPTURE_DELAY = 2'h2;

    typedef enum logic [1:0]
    {
        FRP_LEVEL_NONE,
        FRP_LEVEL_ONE,
        FRP_LEVEL_TWO,
        FRP_LEVEL_THREE
    } frp_level_t;

    // Programming operation offered by a requester
    typedef enum logic [2:0]
    {
        FRP_OP_READ,
        FRP_OP_WRITE,
        FRP_OP_ERASE_SECTOR,
        FRP_OP_ERASE_ALL,
        FRP_OP_GO,
        FRP_OP_OTHER
    } frp_op_t;

    // One request to the flash from some source
    typedef struct packed
    {
        logic valid;
        frp_op_t op;
        logic [7:0] sector;
    } frp_req_t;

    // Gating answer to one request
    typedef struct packed
    {
        logic grant;
        logic refuse;
    } frp_ans_t;

endpackage : frp_pkg

/* File: hw/frp_gate.sv */
/*
 * Flash read protection gate. Captures the protection level once after
 * reset, drives the debug, factory test and boot-mode enables, and answers
 * flash operation requests from the programming path and from user code.
 * Every decision is a pure function of the held level, so the gating is
 * fixed for the whole time between two resets and no request sequence can
 * talk it round; only the level-two erase memory adds state of its own.
 * The level register resets to level three, the safest reading, so nothing
 * is opened while the stored word is still being fetched.
 * Requests seen before the level is known get no answer at all.
 * Assumes protect_word and boot_override_pin are stable around reset release,
 * that both request ports are synchronous to clk and carry at most one
 * request per cycle each, and that requesters look for grant or refuse
 * exactly one cycle after the request.
 */
`timescale 1ns/1ns
module frp_gate
    import frp_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [31:0] protect_word,
    input wire logic boot_override_pin,
    input frp_req_t isp_req,
    input frp_req_t user_req,
    output frp_level_t level,
    output logic level_valid,
    output logic jtag_enable,
    output logic factory_test_enable,
    output logic isp_boot,
    output frp_ans_t isp_ans,
    output frp_ans_t user_ans
);

    // Edges counted since reset release, until the stored word is decoded
    logic [1:0] capture_count;
    // Set once a programming-path whole-chip erase has been taken at level two
    logic full_erased;
    // High in the one cycle whose edge takes the level
    logic capture_now;
    // Level that the stored word selects, before it is held
    frp_level_t word_level;
    // A request is only taken once the level is known
    logic isp_take;
    logic user_take;
    // Verdicts on the requests now standing at the two ports
    logic isp_ok;
    logic user_ok;
    // Values the held registers take on the next edge
    logic next_jtag_enable;
    logic next_factory_test_enable;
    logic next_isp_boot;

    // Decodes the stored word into one of three levels or none
    // Any unrecognised word reads as no protection, so a blank part stays open
    function automatic frp_level_t decode_level(input logic [31:0] word);
        case (word)
            FRP_WORD_LEVEL_ONE: decode_level = FRP_LEVEL_ONE;
            FRP_WORD_LEVEL_TWO: decode_level = FRP_LEVEL_TWO;
            FRP_WORD_LEVEL_THREE: decode_level = FRP_LEVEL_THREE;
            default: decode_level = FRP_LEVEL_NONE;
        endcase
    endfunction : decode_level

    // Judges a programming-path request against the held level
    // Level one: updates away from the boot sector. Level two: erase first,
    // then update. Level three and anything unexpected: nothing at all.
    function automatic logic isp_allowed(input frp_level_t lv, input frp_req_t rq,
                                         input logic erased);
        case (lv)
            FRP_LEVEL_NONE: isp_allowed = 1'b1;
            FRP_LEVEL_ONE:
                isp_allowed = (rq.op == FRP_OP_WRITE || rq.op == FRP_OP_ERASE_SECTOR
                               || rq.op == FRP_OP_GO) && rq.sector != FRP_BOOT_SECTOR;
            FRP_LEVEL_TWO:
                isp_allowed = rq.op == FRP_OP_ERASE_ALL
                              || (erased && (rq.op == FRP_OP_WRITE || rq.op == FRP_OP_GO));
            default: isp_allowed = 1'b0;
        endcase
    endfunction : isp_allowed

    // Judges a user-code request; user code keeps its own update path at
    // every level, so only the mass erase under level one is turned away
    function automatic logic user_allowed(input frp_level_t lv, input frp_req_t rq);
        case (lv)
            FRP_LEVEL_ONE: user_allowed = rq.op != FRP_OP_ERASE_ALL;
            default: user_allowed = 1'b1;
        endcase
    endfunction : user_allowed

    // Debug port opens only when no protection is set at all
    function automatic logic debug_open(input frp_level_t lv);
        case (lv)
            FRP_LEVEL_NONE: debug_open = 1'b1;
            FRP_LEVEL_ONE: debug_open = 1'b0;
            FRP_LEVEL_TWO: debug_open = 1'b0;
            default: debug_open = 1'b0;
        endcase
    endfunction : debug_open

    // Factory test stays possible below level three; level three is one-way
    function automatic logic test_open(input frp_level_t lv);
        case (lv)
            FRP_LEVEL_THREE: test_open = 1'b0;
            default: test_open = 1'b1;
        endcase
    endfunction : test_open

    // Boot pin is honoured below level three; at level three it is ignored outright
    function automatic logic boot_honoured(input frp_level_t lv, input logic pin_level);
        case (lv)
            FRP_LEVEL_THREE: boot_honoured = 1'b0;
            default: boot_honoured = !pin_level;
        endcase
    endfunction : boot_honoured

    // Pure decoding of the held state and the ports; everything is registered
    // below, so no answer or enable ever glitches at an output
    always_comb
    begin
        capture_now = !level_valid && capture_count == FRP_CAPTURE_DELAY;
        word_level = decode_level(protect_word);
        isp_take = level_valid && isp_req.valid;
        user_take = level_valid && user_req.valid;
        isp_ok = isp_allowed(level, isp_req, full_erased);
        user_ok = user_allowed(level, user_req);
        next_jtag_enable = level_valid && debug_open(level);
        next_factory_test_enable = level_valid && test_open(level);
        next_isp_boot = boot_honoured(word_level, boot_override_pin);
    end

    // Edge counter after release; the stored word may still be settling on the
    // first edges, so it is read only a fixed delay later
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            capture_count <= 2'h0;
        end
        else if (!level_valid && !capture_now)
        begin
            capture_count <= capture_count + 2'h1;
        end
    end

    // Level is taken once and then frozen until the next reset, so gating cannot drift
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            level_valid <= 1'b0;
            level <= FRP_LEVEL_THREE; // Safest value until the word is read
            isp_boot <= 1'b0;
        end
        else if (capture_now)
        begin
            level_valid <= 1'b1;
            level <= word_level;
            isp_boot <= next_isp_boot;
        end
    end

    // Debug and test enables follow the held level, one cycle behind it.
    // Both stay low during capture, so the debug port never opens on the
    // reset value of the level, not even for a cycle.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            jtag_enable <= 1'b0;
            factory_test_enable <= 1'b0;
        end
        else
        begin
            jtag_enable <= next_jtag_enable;
            factory_test_enable <= next_factory_test_enable;
        end
    end

    // Level two remembers that a programming-path whole-chip erase has been performed.
    // Only a taken request counts; an erase offered before capture is not
    // remembered, and only a reset forgets it again.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            full_erased <= 1'b0;
        end
        else if (isp_take && isp_req.op == FRP_OP_ERASE_ALL && level == FRP_LEVEL_TWO)
        begin
            full_erased <= 1'b1;
        end
    end

    // Programming-path answers, registered on the taking edge. Exactly one of
    // grant and refuse pulses per taken request, so a host never has to time out.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            isp_ans <= '0;
        end
        else
        begin
            isp_ans.grant <= isp_take && isp_ok;
            isp_ans.refuse <= isp_take && !isp_ok;
        end
    end

    // User-code answers; only a mass erase under level one is turned away, since
    // user code must keep its own update path even at level three.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            user_ans <= '0;
        end
        else
        begin
            user_ans.grant <= user_take && user_ok;
            user_ans.refuse <= user_take && !user_ok;
        end
    end

endmodule : frp_gate

/* File: verification/frp_gate_checker.sv */
/* Port checker for frp_gate, bound below; one clock, synchronous reset */
`timescale 1ns/1ns
module frp_gate_checker
    import frp_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic boot_override_pin,
    input frp_req_t isp_req,
    input frp_req_t user_req,
    input frp_level_t level,
    input wire logic level_valid,
    input wire logic jtag_enable,
    input wire logic factory_test_enable,
    input wire logic isp_boot,
    input frp_ans_t isp_ans,
    input frp_ans_t user_ans
);
    logic vd;
    wire tk = level_valid && isp_req.valid;
    // Enables lag the captured level by a cycle, so gate on a delayed valid
    always_ff @(posedge clk)
    begin
        vd <= nrst && level_valid;
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);
    a_jtag_gate: assert property (vd |-> jtag_enable == (level == FRP_LEVEL_NONE))
        else $error("debug gate wrong");
    a_test_gate: assert property (vd |-> factory_test_enable == (level != FRP_LEVEL_THREE))
        else $error("test gate wrong");
    a_level_held: assert property (vd |-> $stable(level))
        else $error("level moved");
    a_three_boot: assert property (level == FRP_LEVEL_THREE |-> !isp_boot)
        else $error("boot at level three");
    a_three_refuse: assert property (tk && level == FRP_LEVEL_THREE |=> isp_ans.refuse)
        else $error("level three let through");
    a_sector_zero: assert property (tk && level == FRP_LEVEL_ONE && isp_req.sector == 8'h00
        |=> isp_ans.refuse) else $error("sector zero touched");
    a_user_erase: assert property (level_valid && user_req.valid && level == FRP_LEVEL_ONE
        && user_req.op == FRP_OP_ERASE_ALL |=> user_ans.refuse) else $error("mass erase");
    a_two_erase: assert property (tk && level == FRP_LEVEL_TWO && isp_req.op == FRP_OP_ERASE_ALL
        |=> isp_ans.grant) else $error("full erase refused");
    a_boot_pin: assert property ($rose(level_valid)
        |-> isp_boot == (level != FRP_LEVEL_THREE && !boot_override_pin))
        else $error("boot pin not honoured");
endmodule : frp_gate_checker
bind frp_gate frp_gate_checker chk (.clk(clk), .nrst(nrst), .isp_req(isp_req),
    .boot_override_pin(boot_override_pin),
    .user_req(user_req), .level(level), .level_valid(level_valid), .jtag_enable(jtag_enable),
    .factory_test_enable(factory_test_enable), .isp_boot(isp_boot), .isp_ans(isp_ans),
    .user_ans(user_ans));

/* File: verification/frp_host.sv */
/* Programming host model; the bench raises fire for one cycle per request */
`timescale 1ns/1ns
module frp_host
    import frp_pkg::*;
(
    input wire logic clk,
    input wire logic fire,
    input frp_op_t op,
    input wire logic [7:0] sector,
    output frp_req_t req
);
    // Released sector lines flip so a stale value never looks valid
    always_ff @(posedge clk)
    begin
        req <= fire ? frp_req_t'{1'b1, op, sector} : frp_req_t'{1'b0, req.op, ~req.sector};
    end
endmodule : frp_host

/* File: verification/test_frp_gate.sv */
/* Bench for frp_gate: level table, then hand cases; host model drives isp_req */
`timescale 1ns/1ns
module test_frp_gate
    import frp_pkg::*;
();
    // Row: stored word and request in; level, debug, test, boot and grant out
    typedef struct packed {logic [31:0] w; frp_level_t lv; frp_op_t op; logic [7:0] s;
        logic j; logic f; logic b; logic g;} frp_row_t;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic pin = 1'b0;
    logic fire = 1'b0;
    logic [31:0] word = 32'h0;
    frp_op_t hop = FRP_OP_READ;
    logic [7:0] hsec = 8'h0;
    frp_req_t req;
    frp_req_t ureq = '0;
    frp_level_t level;
    frp_ans_t ians;
    frp_ans_t uans;
    logic boot;
    logic lvd;
    logic jtag;
    logic ftest;
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;
    frp_row_t rows [7] = '{'{32'h0, FRP_LEVEL_NONE, FRP_OP_READ, 8'h00, 1'b1, 1'b1, 1'b1, 1'b1},
        '{FRP_WORD_LEVEL_ONE, FRP_LEVEL_ONE, FRP_OP_WRITE, 8'h01, 1'b0, 1'b1, 1'b1, 1'b1},
        '{FRP_WORD_LEVEL_ONE, FRP_LEVEL_ONE, FRP_OP_WRITE, 8'h00, 1'b0, 1'b1, 1'b1, 1'b0},
        '{FRP_WORD_LEVEL_ONE, FRP_LEVEL_ONE, FRP_OP_ERASE_ALL, 8'h01, 1'b0, 1'b1, 1'b1, 1'b0},
        '{FRP_WORD_LEVEL_TWO, FRP_LEVEL_TWO, FRP_OP_WRITE, 8'h01, 1'b0, 1'b1, 1'b1, 1'b0},
        '{FRP_WORD_LEVEL_TWO, FRP_LEVEL_TWO, FRP_OP_ERASE_ALL, 8'h00, 1'b0, 1'b1, 1'b1, 1'b1},
        '{FRP_WORD_LEVEL_THREE, FRP_LEVEL_THREE, FRP_OP_GO, 8'h02, 1'b0, 1'b0, 1'b0, 1'b0}};
    frp_gate dut (.clk(clk), .nrst(nrst), .protect_word(word), .boot_override_pin(pin),
        .isp_req(req), .user_req(ureq), .level(level), .level_valid(lvd), .jtag_enable(jtag),
        .factory_test_enable(ftest), .isp_boot(boot), .isp_ans(ians), .user_ans(uans));
    frp_host host (.clk(clk), .fire(fire), .op(hop), .sector(hsec), .req(req));
    // Clock and the hang limit
    always #10 clk = ~clk;
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 1000)
        begin
            err_count++;
            close_out();
        end
    end
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            $display("BAD %0t got %h want %h", $time, seen, exp);
            err_count++;
        end
    endtask : chk
    // Three cycles of reset, then wait until the level and enables have settled
    task rst(input logic [31:0] w, input logic p);
        @(posedge clk);
        nrst <= 1'b0;
        word <= w;
        pin <= p;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : rst
    task send(input frp_op_t o, input logic [7:0] s);
        @(posedge clk);
        fire <= 1'b1;
        hop <= o;
        hsec <= s;
        @(posedge clk);
        fire <= 1'b0;
        @(posedge clk);
        #1;
    endtask : send
    task close_out();
        $display("errors %0d of %0d compares", err_count, n_compared);
        if (err_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out
    initial
    begin
        foreach (rows[i])
        begin
            rst(rows[i].w, 1'b0);
            send(rows[i].op, rows[i].s);
            chk({lvd, jtag, ftest, boot, level, ians},
                {1'b1, rows[i].j, rows[i].f, rows[i].b, rows[i].lv, rows[i].g, !rows[i].g});
        end
        // Full erase first, then the update is let through
        rst(FRP_WORD_LEVEL_TWO, 1'b0);
        send(FRP_OP_ERASE_ALL, 8'h00);
        send(FRP_OP_WRITE, 8'h03);
        chk({4'h0, boot, 1'b0, ians}, 8'h0A);
        // Pin high, back-to-back user requests, word changed after capture
        rst(FRP_WORD_LEVEL_ONE, 1'b1);
        @(posedge clk);
        ureq <= '{1'b1, FRP_OP_ERASE_ALL, 8'h01};
        word <= FRP_WORD_LEVEL_THREE;
        @(posedge clk);
        ureq <= '{1'b1, FRP_OP_WRITE, 8'h01};
        #1 chk({4'h0, boot, 1'b0, uans}, 8'h01);
        @(posedge clk);
        ureq <= '0;
        #1 chk({4'h0, level, uans}, {4'h0, FRP_LEVEL_ONE, 2'h2});
        // Reset in mid-run: two edges later every output but uans is checked back at its reset value
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk({lvd, jtag, ftest, boot, level, ians}, {4'h0, FRP_LEVEL_THREE, 2'h0});
        // Level three: a low boot pin is ignored, user code keeps its own update path
        rst(FRP_WORD_LEVEL_THREE, 1'b0);
        ureq <= '{1'b1, FRP_OP_WRITE, 8'h05};
        @(posedge clk);
        ureq <= '0;
        #1 chk({lvd, jtag, ftest, boot, level, uans}, {4'h8, FRP_LEVEL_THREE, 2'h2});
        close_out();
    end
endmodule : test_frp_gate
